/* hw/oss_osc_select.sv */
`timescale 1ns/1ps
`default_nettype none
module oss_osc_select
  import oss_pkg::*;
#(
  parameter int SLOW_LOSS_CYCLES = SLOW_LOSS_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] cfg_hs_osc_i,
  input  wire logic       cfg_slow_xtal_en_i,
  input  wire logic [1:0] cfg_irc_freq_i,
  input  wire logic       ctrl_wr_i,
  input  wire logic [7:0] ctrl_wdata_i,
  output logic      [7:0] ctrl_rdata_o,
  input  wire logic       sleep_i,
  input  wire logic       osc_pin_in_i,
  output logic            osc_pin_out_o,
  output logic            osc_pin_out_oe_o,
  output logic            port_a_pin5_is_io_o,
  output logic            port_a_pin6_is_io_o,
  output logic            sysclk_o,
  output logic            sysclk_is_slow_o,
  output logic            halted_o,
  output logic            fast_int_rc_run_o,
  output logic            slow_xtal_run_o,
  output logic            slow_xtal_ok_o,
  output logic            slow_xtal_low_power_o,
  output logic            timer_clk_o,
  output logic            wdt_clk_o
);

  // Configuration decode.
  logic        hs_xtal;
  logic        hs_erc;
  logic        hs_int;
  logic        slow_cfg;
  logic        pin_in_used;
  logic        pin_out_used;

  // Oscillator pin and derived levels.
  logic        osc_in_s;
  logic        irc_lvl;
  logic        fast_lvl;
  logic        slow_lvl;
  logic        cur_lvl;
  logic [31:0] irc_inc;

  // Software control bits.
  logic [1:0]  ctrl_r;
  logic [1:0]  ctrl_nxt;

  // Pin drive state.
  logic        drv_r;
  logic        drv_nxt;
  logic        drv_oe_r;
  logic        drv_oe_nxt;
  logic        pin5_io_r;
  logic        pin5_io_nxt;
  logic        pin6_io_r;
  logic        pin6_io_nxt;

  // Slow crystal presence monitor.
  logic                  slow_d_r;
  logic                  slow_d_nxt;
  logic [LOSS_CNT_W-1:0] loss_cnt_r;
  logic [LOSS_CNT_W-1:0] loss_cnt_nxt;
  logic [2:0]            edge_cnt_r;
  logic [2:0]            edge_cnt_nxt;
  logic                  slow_ok;
  logic                  timer_r;
  logic                  timer_nxt;

  // Clock switch state.
  oss_state_e  state_r;
  oss_state_e  state_nxt;
  logic        src_slow_r;
  logic        src_slow_nxt;
  logic        cur_prev_r;
  logic        cur_prev_nxt;
  logic        sysclk_r;
  logic        sysclk_nxt;
  logic        halted_r;
  logic        halted_nxt;
  logic        irc_run_r;
  logic        irc_run_nxt;
  logic        want_slow;
  logic        want_run;

  always_comb begin
    hs_xtal      = (cfg_hs_osc_i == HS_CFG_XTAL);
    hs_erc       = (cfg_hs_osc_i == HS_CFG_ERC);
    hs_int       = (cfg_hs_osc_i == HS_CFG_IRC);
    slow_cfg     = hs_int & cfg_slow_xtal_en_i;
    pin_in_used  = hs_xtal | hs_erc | slow_cfg;
    pin_out_used = hs_xtal | slow_cfg;
  end

  oss_sync2 u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (osc_pin_in_i),
    .q_o       (osc_in_s)
  );

  always_comb begin
    unique case (cfg_irc_freq_i)
      IRC_FRQ_8M:  irc_inc = INC_IRC_8M;
      IRC_FRQ_12M: irc_inc = INC_IRC_12M;
      default:     irc_inc = INC_IRC_4M;
    endcase
  end

  oss_nco u_fast_int_rc (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .en_i      (irc_run_r),
    .inc_i     (irc_inc),
    .lvl_o     (irc_lvl)
  );

  // The watchdog clock is never gated, not even in sleep.
  oss_nco u_slow_int_rc (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .en_i      (1'b1),
    .inc_i     (INC_SLOW_RC),
    .lvl_o     (wdt_clk_o)
  );

  always_comb begin
    fast_lvl = hs_int ? irc_lvl : osc_in_s;
    // The low power bit only trims the amplifier; the clock path ignores it.
    slow_lvl = slow_cfg & osc_in_s;
    cur_lvl  = src_slow_r ? slow_lvl : fast_lvl;
  end

  // Control bits written by software.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr_i) begin
      ctrl_nxt[CTRL_SRC_BIT] = ctrl_wdata_i[CTRL_SRC_BIT];
      ctrl_nxt[CTRL_LP_BIT]  = ctrl_wdata_i[CTRL_LP_BIT];
    end
  end

  // Pin ownership and crystal amplifier drive.
  always_comb begin
    drv_nxt     = ~osc_in_s;
    drv_oe_nxt  = pin_out_used;
    pin5_io_nxt = ~pin_out_used;
    pin6_io_nxt = ~pin_in_used;
  end

  // A slow crystal still starting up or lost is not offered as a source,
  // so the system clock can never hang on a dead oscillator.
  always_comb begin
    slow_d_nxt   = slow_lvl;
    loss_cnt_nxt = loss_cnt_r;
    edge_cnt_nxt = edge_cnt_r;
    if (slow_lvl != slow_d_r) begin
      loss_cnt_nxt = '0;
      if (edge_cnt_r != SLOW_GOOD_EDGES) begin
        edge_cnt_nxt = edge_cnt_r + 3'h1;
      end
    end else if (loss_cnt_r == LOSS_CNT_W'(SLOW_LOSS_CYCLES - 1)) begin
      loss_cnt_nxt = '0;
      edge_cnt_nxt = 3'h0;
    end else begin
      loss_cnt_nxt = loss_cnt_r + {{(LOSS_CNT_W-1){1'b0}}, 1'b1};
    end
    slow_ok   = (edge_cnt_r == SLOW_GOOD_EDGES);
    timer_nxt = slow_lvl;
  end

  always_comb begin
    want_slow = slow_cfg & ctrl_r[CTRL_SRC_BIT] & slow_ok;
    want_run  = ~sleep_i;
  end

  // Gated clock switch: the output is parked only while the running source
  // is low or is a lost slow crystal, and relaunched only on a falling edge of the new source.
  always_comb begin
    state_nxt    = state_r;
    src_slow_nxt = src_slow_r;
    cur_prev_nxt = cur_lvl;
    unique case (state_r)
      ST_RUN: begin
        // A lost slow crystal may hang at high; its stretched pulse is already long.
        if (((want_slow != src_slow_r) || !want_run)
            && (!cur_lvl || (src_slow_r && !slow_ok))) begin
          state_nxt = ST_GATED;
        end
      end
      ST_GATED: begin
        if (want_run) begin
          src_slow_nxt = want_slow;
          state_nxt    = ST_LAUNCH;
        end
      end
      ST_LAUNCH: begin
        if (!want_run || (want_slow != src_slow_r)) begin
          state_nxt = ST_GATED;
        end else if (cur_prev_r && !cur_lvl) begin
          state_nxt = ST_RUN;
        end
      end
    endcase
    sysclk_nxt = (state_nxt == ST_RUN) & cur_lvl;
    halted_nxt = (state_nxt == ST_GATED) & ~want_run;
    // The fast RC stops in slow mode and in sleep.
    // The fast RC restarts in the cycle the switch leaves ST_GATED with it as source (back from slow mode or sleep), and starts one cycle after reset.
    irc_run_nxt = hs_int
                & ~src_slow_nxt
                & ~((state_nxt == ST_GATED) & (~want_run | want_slow));
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r     <= CTRL_RESET;
      drv_r      <= 1'b0;
      drv_oe_r   <= 1'b0;
      pin5_io_r  <= 1'b1;
      pin6_io_r  <= 1'b1;
      slow_d_r   <= 1'b0;
      loss_cnt_r <= '0;
      edge_cnt_r <= 3'h0;
      timer_r    <= 1'b0;
      state_r    <= ST_LAUNCH;
      src_slow_r <= 1'b0;
      cur_prev_r <= 1'b0;
      sysclk_r   <= 1'b0;
      halted_r   <= 1'b0;
      irc_run_r  <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      drv_r      <= drv_nxt;
      drv_oe_r   <= drv_oe_nxt;
      pin5_io_r  <= pin5_io_nxt;
      pin6_io_r  <= pin6_io_nxt;
      slow_d_r   <= slow_d_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      timer_r    <= timer_nxt;
      state_r    <= state_nxt;
      src_slow_r <= src_slow_nxt;
      cur_prev_r <= cur_prev_nxt;
      sysclk_r   <= sysclk_nxt;
      halted_r   <= halted_nxt;
      irc_run_r  <= irc_run_nxt;
    end
  end

  assign ctrl_rdata_o          = {CTRL_PAD, ctrl_r};
  assign osc_pin_out_o         = drv_r;
  assign osc_pin_out_oe_o      = drv_oe_r;
  assign port_a_pin5_is_io_o   = pin5_io_r;
  assign port_a_pin6_is_io_o   = pin6_io_r;
  assign sysclk_o              = sysclk_r;
  assign sysclk_is_slow_o      = src_slow_r;
  assign halted_o              = halted_r;
  assign fast_int_rc_run_o     = irc_run_r;
  assign slow_xtal_run_o       = slow_cfg;
  assign slow_xtal_ok_o        = slow_ok;
  assign slow_xtal_low_power_o = ctrl_r[CTRL_LP_BIT];
  assign timer_clk_o           = timer_r;

endmodule
`default_nettype wire

/* hw/oss_pkg.sv */
// Overview of operation
// - Slow crystal as sysclk only with internal RC.
// - Free-running 15kHz slow RC clocks the watchdog.
// - Internal fast RC runs at 4, 8 or 12MHz.
// - Fast crystal option claims both oscillator pins.
// - External RC uses pin six only, pin five free.
// - Internal RC frees pins, or slow crystal uses them.
// - Slow crystal across both pins gives independent clock.
// - Sleep stops system clock; independent clock keeps running.
// - Low power bit: 0 quick start, 1 low power.
// - Low power bit clears to zero at power-on.
// - Slow crystal runs normally whatever the mode bit.
// - Source bit 0 fast RC, 1 slow crystal, RC stopped.
// - Low power bit sits at control bit 1.
// - Slow crystal keeps running during halt sleep.
package oss_pkg;

  localparam int          REF_CLK_HZ     = 125_000_000;
  localparam int          REF_PERIOD_NS  = 8;

  localparam logic [1:0]  HS_CFG_XTAL    = 2'h0;
  localparam logic [1:0]  HS_CFG_ERC     = 2'h1;
  localparam logic [1:0]  HS_CFG_IRC     = 2'h2;

  localparam logic [1:0]  IRC_FRQ_4M     = 2'h0;
  localparam logic [1:0]  IRC_FRQ_8M     = 2'h1;
  localparam logic [1:0]  IRC_FRQ_12M    = 2'h2;

  localparam longint      IRC_4M_HZ      = 4_000_000;
  localparam longint      IRC_8M_HZ      = 8_000_000;
  localparam longint      IRC_12M_HZ     = 12_000_000;
  localparam longint      SLOW_RC_HZ     = 15_000;
  localparam longint      SLOW_XTAL_HZ   = 32_768;

  localparam logic [31:0] INC_IRC_4M     = 32'((IRC_4M_HZ << 32) / longint'(REF_CLK_HZ));
  localparam logic [31:0] INC_IRC_8M     = 32'((IRC_8M_HZ << 32) / longint'(REF_CLK_HZ));
  localparam logic [31:0] INC_IRC_12M    = 32'((IRC_12M_HZ << 32) / longint'(REF_CLK_HZ));
  localparam logic [31:0] INC_SLOW_RC    = 32'((SLOW_RC_HZ << 32) / longint'(REF_CLK_HZ));

  localparam int          CTRL_SRC_BIT   = 0;
  localparam int          CTRL_LP_BIT    = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [5:0]  CTRL_PAD       = 6'h00;

  localparam int          SLOW_LOSS_NS   = 200_000;
  localparam int          SLOW_LOSS_CYC  = SLOW_LOSS_NS / REF_PERIOD_NS;
  localparam int          LOSS_CNT_W     = 16;
  localparam logic [2:0]  SLOW_GOOD_EDGES = 3'h4;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_GATED,
    ST_LAUNCH
  } oss_state_e;

endpackage

/* hw/oss_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module oss_sync2 (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule
`default_nettype wire

/* hw/oss_nco.sv */
`timescale 1ns/1ps
`default_nettype none
module oss_nco (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        en_i,
  input  wire logic [31:0] inc_i,
  output logic             lvl_o
);

  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic        lvl_r;
  logic        lvl_nxt;

  // A stopped oscillator parks low so a restart begins with a whole low phase.
  always_comb begin
    acc_nxt = en_i ? acc_r + inc_i : 32'h0000_0000;
    lvl_nxt = acc_nxt[31];
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_r <= 32'h0000_0000;
      lvl_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign lvl_o = lvl_r;

endmodule
`default_nettype wire

/* testbench/oss_osc_select_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module oss_chk (
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire logic [1:0] cfg_hs_osc_i,
  input wire logic       cfg_slow_xtal_en_i,
  input wire logic       ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [7:0] ctrl_rdata_o,
  input wire logic       port_a_pin5_is_io_o,
  input wire logic       port_a_pin6_is_io_o,
  input wire logic       sysclk_o,
  input wire logic       sysclk_is_slow_o,
  input wire logic       halted_o,
  input wire logic       fast_int_rc_run_o,
  input wire logic       slow_xtal_ok_o,
  input wire logic       slow_xtal_low_power_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  ctrl_write_a: assert property (ctrl_wr_i |=> ctrl_rdata_o == {6'h00, $past(ctrl_wdata_i[1:0])})
    else $error("control bits not taken");
  low_power_a: assert property (ctrl_wr_i |=> slow_xtal_low_power_o == $past(ctrl_wdata_i[1]))
    else $error("low power bit wrong");
  boot_quick_a: assert property ($rose(arst_n_i) |-> !slow_xtal_low_power_o && ctrl_rdata_o == 8'h00)
    else $error("control bits not cleared");
  xtal_pins_a: assert property (cfg_hs_osc_i == 2'h0 ##1 cfg_hs_osc_i == 2'h0 |-> !port_a_pin5_is_io_o && !port_a_pin6_is_io_o)
    else $error("crystal pins released");
  rc_pins_a: assert property (cfg_hs_osc_i == 2'h1 ##1 cfg_hs_osc_i == 2'h1 |-> port_a_pin5_is_io_o && !port_a_pin6_is_io_o)
    else $error("rc pin use wrong");
  irc_pins_a: assert property (cfg_hs_osc_i == 2'h2 ##1 cfg_hs_osc_i == 2'h2 && $stable(cfg_slow_xtal_en_i) |-> port_a_pin5_is_io_o == !cfg_slow_xtal_en_i && port_a_pin6_is_io_o == !cfg_slow_xtal_en_i)
    else $error("internal rc pin use wrong");
  slow_gate_a: assert property ($rose(sysclk_is_slow_o) |-> cfg_hs_osc_i == 2'h2 && cfg_slow_xtal_en_i && ctrl_rdata_o[0] && slow_xtal_ok_o)
    else $error("slow source taken illegally");
  rc_stop_a: assert property (sysclk_is_slow_o |-> !fast_int_rc_run_o)
    else $error("fast rc runs on slow clock");
  sleep_park_a: assert property (halted_o |-> !sysclk_o)
    else $error("clock runs while halted");
  clean_swap_a: assert property ($changed(sysclk_is_slow_o) |-> !sysclk_o)
    else $error("source swapped with clock high");
endmodule
bind oss_osc_select oss_chk CHK (.ref_clk_i, .arst_n_i, .cfg_hs_osc_i, .cfg_slow_xtal_en_i,
  .ctrl_wr_i, .ctrl_wdata_i, .ctrl_rdata_o, .port_a_pin5_is_io_o, .port_a_pin6_is_io_o,
  .sysclk_o, .sysclk_is_slow_o, .halted_o, .fast_int_rc_run_o, .slow_xtal_ok_o,
  .slow_xtal_low_power_o);
`default_nettype wire

/* testbench/oss_xtal_model.sv */
`timescale 1ns/1ps
`default_nettype none
module oss_xtal_model (
  input  wire logic       ref_clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            pin_o
);
  // A stopped crystal leaves the pin at a steady level, so loss can be seen.
  initial begin
    pin_o = 1'b0;
    forever begin
      repeat (half_i) @(posedge ref_clk_i);
      if (run_i)
        pin_o <= ~pin_o;
    end
  end
endmodule
`default_nettype wire

/* testbench/test_oss_osc_select.sv */
`timescale 1ns/1ps
`default_nettype none
module test_oss_osc_select;
  logic       ref_clk_i = 1'b0;
  logic       arst_n_i  = 1'b0;
  logic [1:0] cfg_hs    = 2'h2;
  logic       cfg_slow  = 1'b0;
  logic [1:0] cfg_frq   = 2'h0;
  logic       wr        = 1'b0;
  logic [7:0] wd        = 8'h00;
  logic       sleep     = 1'b0;
  logic       x_run     = 1'b0;
  logic       pin, oe, p5, p6, sclk, slow, halt, rc_run, ok, lp, tclk, wclk;
  logic       pout, srun;
  logic [7:0] rd;
  int         err_total = 0;
  int         comparisons = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  oss_xtal_model XM (.ref_clk_i(ref_clk_i), .run_i(x_run), .half_i(8'h14), .pin_o(pin));
  // A short loss count keeps the fallback case within a few hundred cycles.
  oss_osc_select #(.SLOW_LOSS_CYCLES(64)) DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .cfg_hs_osc_i(cfg_hs), .cfg_slow_xtal_en_i(cfg_slow), .cfg_irc_freq_i(cfg_frq),
    .ctrl_wr_i(wr), .ctrl_wdata_i(wd), .ctrl_rdata_o(rd), .sleep_i(sleep),
    .osc_pin_in_i(pin), .osc_pin_out_o(pout), .osc_pin_out_oe_o(oe),
    .port_a_pin5_is_io_o(p5), .port_a_pin6_is_io_o(p6), .sysclk_o(sclk),
    .sysclk_is_slow_o(slow), .halted_o(halt), .fast_int_rc_run_o(rc_run),
    .slow_xtal_run_o(srun), .slow_xtal_ok_o(ok), .slow_xtal_low_power_o(lp),
    .timer_clk_o(tclk), .wdt_clk_o(wclk));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic wctl(input logic [7:0] d);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    wd <= d;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    @(negedge ref_clk_i);
  endtask
  task automatic cnt(input int sel, input int n, output int c);
    logic p, v;
    c = 0;
    p = 1'b1;
    repeat (n) begin
      @(negedge ref_clk_i);
      v = (sel == 0) ? sclk : (sel == 1) ? tclk : wclk;
      c += int'(v && !p);
      p = v;
    end
  endtask
  task automatic t_ctrl;
    @(negedge ref_clk_i);
    chk("rd", 8'h00, rd);
    wctl(8'hFF);
    chk("rd", 8'h03, rd);
    wctl(8'h02);
    chk("lp", 8'h01, {7'h00, lp});
    wctl(8'h00);
  endtask
  task automatic t_freq;
    int c;
    // 3000 cycles of 8 ns hold 96 periods at 4 MHz.
    for (int j = 0; j < 3; j++) begin
      @(posedge ref_clk_i);
      cfg_frq <= 2'(j);
      cnt(0, 20, c);
      cnt(0, 3000, c);
      chk("irc", 8'h01, 8'(c inside {[96 * (j + 1) - 1 : 96 * (j + 1) + 1]}));
    end
  endtask
  task automatic t_pins;
    logic [2:0] e [4] = '{3'h4, 3'h2, 3'h3, 3'h4};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      cfg_hs <= (i == 3) ? 2'h2 : 2'(i);
      cfg_slow <= (i == 3);
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("pins", {5'h00, e[i]}, {5'h00, oe, p5, p6});
      chk("drive", {6'h00, 1'b1, 1'(i == 3)}, {6'h00, pout, srun});
    end
  endtask
  task automatic t_slow;
    int c;
    @(posedge ref_clk_i);
    x_run <= 1'b1;
    cnt(0, 200, c);
    wctl(8'h03);
    for (int k = 0; k < 100 && slow !== 1'b1; k++) @(negedge ref_clk_i);
    chk("slow", 8'h01, {7'h00, slow});
    chk("rc_run", 8'h00, {7'h00, rc_run});
    cnt(0, 400, c);
    chk("slow_clk", 8'h01, 8'(c inside {[9:11]}));
  endtask
  task automatic t_sleep;
    int c;
    @(posedge ref_clk_i);
    sleep <= 1'b1;
    cnt(0, 100, c);
    chk("halt", 8'h01, {7'h00, halt});
    cnt(0, 400, c);
    chk("sys_edges", 8'h00, 8'(c));
    cnt(1, 400, c);
    chk("tmr_clk", 8'h01, 8'(c inside {[9:11]}));
    cnt(2, 10000, c);
    chk("wdt_clk", 8'h01, 8'(c inside {[1:2]}));
    @(posedge ref_clk_i);
    sleep <= 1'b0;
  endtask
  task automatic t_loss;
    int c;
    @(posedge ref_clk_i);
    x_run <= 1'b0;
    cnt(0, 300, c);
    chk("lost", 8'h00, {6'h00, ok, slow});
    @(posedge ref_clk_i);
    cfg_hs <= 2'h1;
    x_run <= 1'b1;
    cnt(0, 300, c);
    chk("erc_slow", 8'h00, {7'h00, slow});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    results();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_ctrl();
    t_freq();
    t_pins();
    t_slow();
    t_sleep();
    t_loss();
    results();
  end
endmodule
`default_nettype wire
